// file: core/stepper_pkg.sv
/*
  Shared constants and types for the stepper phase sequencer.
  Assumes a single 100 MHz clock domain and synchronous control inputs.
*/
package stepper_pkg;

  // Phase position counter: eight half-step positions
  localparam int unsigned POS_W        = 3;
  localparam logic [2:0]  POS_INIT     = 3'h1;  // A and BB on (odd = two phases on)
  localparam logic [2:0]  POS_STEP_HALF = 3'h1;
  localparam logic [2:0]  POS_STEP_FULL = 3'h2;

  // Fault type codes on the level output (three distinct levels, zero when none)
  localparam logic [1:0]  LVL_NONE     = 2'h0;
  localparam logic [1:0]  LVL_OPEN     = 2'h1;
  localparam logic [1:0]  LVL_OVERCUR  = 2'h2;
  localparam logic [1:0]  LVL_OVERHEAT = 2'h3;

  // Phase output bundle
  typedef struct packed {
    logic a;
    logic a_bar;
    logic b;
    logic b_bar;
  } phases_s;

  localparam phases_s PHASES_OFF = '{a: 1'b0, a_bar: 1'b0, b: 1'b0, b_bar: 1'b0};

  // Protection detector inputs
  typedef struct packed {
    logic open_load;
    logic over_current;
    logic over_heat;
  } detect_s;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_TRIP  = 3'b100
  } seq_state_e;

endpackage : stepper_pkg

// file: core/phase_decode.sv
/*
  Maps a half-step position to the four phase drive levels.
  Assumes the position is a registered value from the sequencer.
*/
`timescale 1ns/1ns
module phase_decode (
  input  wire logic [2:0]         pos,     // Half-step position
  output stepper_pkg::phases_s    phases   // Decoded phase levels
);

  // Even positions: one phase on; odd positions: two adjacent phases on
  always_comb begin
    phases = stepper_pkg::PHASES_OFF;
    unique case (pos)
      3'h0: phases.a = 1'b1;
      3'h1: begin
        phases.a     = 1'b1;
        phases.b_bar = 1'b1;
      end
      3'h2: phases.b_bar = 1'b1;
      3'h3: begin
        phases.b_bar = 1'b1;
        phases.a_bar = 1'b1;
      end
      3'h4: phases.a_bar = 1'b1;
      3'h5: begin
        phases.a_bar = 1'b1;
        phases.b     = 1'b1;
      end
      3'h6: phases.b = 1'b1;
      3'h7: begin
        phases.b = 1'b1;
        phases.a = 1'b1;
      end
    endcase
  end

endmodule : phase_decode

// file: core/stepper_phase_sequencer.sv
/*
  Control logic of a unipolar two-phase stepper driver: phase sequencing on
  step clock edges, enable output cut, latched protection and fault reporting.
  Assumes all inputs are synchronous to clk; the step clock is sampled here.
*/
`timescale 1ns/1ns
module stepper_phase_sequencer (
  input  wire logic                 clk,                // 100 MHz system clock
  input  wire logic                 rst_n,              // Power-on reset, async, active low
  input  wire logic                 system_reset_n,     // System reset pin, active low
  input  wire logic                 enable,             // Output enable, high runs
  input  wire logic                 step_clock,         // External step clock
  input  wire logic                 excitation_select,  // Low 2-phase, high half-step
  input  wire logic                 edge_select,        // High rising only, low both edges
  input  wire logic                 direction_select,   // Low forward, high reverse
  input  wire stepper_pkg::detect_s detect,             // Protection detector levels
  output stepper_pkg::phases_s      phase_out,          // Phase drive A, A bar, B, B bar
  output logic                      any_fault_n,        // Open-drain output level, low on fault
  output logic                      any_fault_oe,       // Drive enable of fault pin
  output logic [1:0]                fault_type_level,   // Fault kind level code
  output logic [2:0]                position            // Current half-step position
);

  stepper_pkg::seq_state_e state;
  stepper_pkg::detect_s    fault_latch;
  logic                    step_prev;
  logic                    step_edge;
  logic                    tripped;
  logic [2:0]              next_position;
  logic [2:0]              stride;
  stepper_pkg::phases_s    decoded;

  assign tripped = |fault_latch;

  // Edge qualification of the step clock
  always_comb begin
    if (edge_select) begin
      step_edge = step_clock & ~step_prev;
    end else begin
      step_edge = step_clock ^ step_prev;
    end
  end

  // Step stride and next position; 2-phase mode snaps to the nearest odd state
  always_comb begin
    stride = excitation_select ? stepper_pkg::POS_STEP_HALF : stepper_pkg::POS_STEP_FULL;
    if (!excitation_select && !position[0]) begin
      // Entering 2-phase from a one-phase state moves a half step onward
      stride = stepper_pkg::POS_STEP_HALF;
    end
    if (direction_select) begin
      next_position = position - stride;
    end else begin
      next_position = position + stride;
    end
  end

  // Step clock history, frozen while disabled so a step clock change made while disabled can count as an edge on return
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_prev <= 1'b0;
    end else if (!system_reset_n) begin
      step_prev <= step_clock;
    end else if (enable) begin
      step_prev <= step_clock;
    end
  end

  // Sequencer state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= stepper_pkg::ST_RESET;
    end else if (!system_reset_n) begin
      state <= stepper_pkg::ST_RESET;
    end else begin
      unique case (state)
        stepper_pkg::ST_RESET: state <= stepper_pkg::ST_RUN;
        stepper_pkg::ST_RUN:   if (tripped) state <= stepper_pkg::ST_TRIP;
        stepper_pkg::ST_TRIP:  state <= stepper_pkg::ST_TRIP;
        default:               state <= stepper_pkg::ST_RESET;
      endcase
    end
  end

  // Position counter: held through enable low and in the ST_TRIP state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position <= stepper_pkg::POS_INIT;
    end else if (!system_reset_n) begin
      position <= stepper_pkg::POS_INIT;
    end else if (enable && state == stepper_pkg::ST_RUN && step_edge) begin
      position <= next_position;
    end
  end

  // Protection latches, cleared only by system reset or power-on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_latch <= '0;
    end else if (!system_reset_n) begin
      fault_latch <= '0;
    end else begin
      fault_latch <= fault_latch | detect;
    end
  end

  phase_decode u_decode (
    .pos    (position),
    .phases (decoded)
  );

  // Phase outputs: off in reset, while disabled and once tripped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_out <= stepper_pkg::PHASES_OFF;
    end else if (!enable || !system_reset_n || tripped || (|detect)) begin
      phase_out <= stepper_pkg::PHASES_OFF;
    end else begin
      phase_out <= decoded;
    end
  end

  // Fault reporting: open-drain pull-down and kind level, priority heat, current, open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      any_fault_n      <= 1'b1;
      any_fault_oe     <= 1'b0;
      fault_type_level <= stepper_pkg::LVL_NONE;
    end else begin
      any_fault_n  <= ~tripped;
      any_fault_oe <= tripped;
      if (fault_latch.over_heat) begin
        fault_type_level <= stepper_pkg::LVL_OVERHEAT;
      end else if (fault_latch.over_current) begin
        fault_type_level <= stepper_pkg::LVL_OVERCUR;
      end else if (fault_latch.open_load) begin
        fault_type_level <= stepper_pkg::LVL_OPEN;
      end else begin
        fault_type_level <= stepper_pkg::LVL_NONE;
      end
    end
  end

endmodule : stepper_phase_sequencer

// file: tb/seq_chk.sv
/* Port checker for the phase sequencer.
   Assumes binding to the top module, one clock domain. */
`timescale 1ns/1ns
module seq_chk (
  input wire logic                 clk,               // Clock
  input wire logic                 rst_n,             // Reset
  input wire logic                 system_reset_n,    // Sync reset
  input wire logic                 enable,            // Run
  input wire logic                 step_clock,        // Step
  input wire logic                 excitation_select, // Mode
  input wire logic                 edge_select,       // Edges
  input wire logic                 direction_select,  // Direction
  input wire stepper_pkg::detect_s detect,            // Detectors
  input wire stepper_pkg::phases_s phase_out,         // Phases
  input wire logic                 any_fault_n,       // Fault pin
  input wire logic                 any_fault_oe,      // Fault drive
  input wire logic [1:0]           fault_type_level,  // Fault kind
  input wire logic [2:0]           position           // Position
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  localparam logic [31:0] DEC = 32'ha2645198;
  logic ok;
  // Running with no fault and no reset
  assign ok = system_reset_n && enable && any_fault_n && detect == 3'h0;
  // Expected position after one step
  function automatic logic [2:0] nxt(logic [2:0] p, logic ex, logic dir);
    nxt = dir ? p - ((ex || !p[0]) ? 3'h1 : 3'h2) : p + ((ex || !p[0]) ? 3'h1 : 3'h2);
  endfunction : nxt
  en_off_a: assert property (!enable |=> phase_out == 4'h0) else $error("phases on while disabled");
  hold_a: assert property (!enable && system_reset_n |=> $stable(position)) else $error("moved while disabled");
  fault_flag_a: assert property ((system_reset_n && detect != 3'h0)[*3] |=> !any_fault_n && any_fault_oe)
    else $error("fault pin not pulled");
  fault_kind_a: assert property (!system_reset_n ##1 (system_reset_n && detect == 3'h4)[*3]
    |=> fault_type_level == stepper_pkg::LVL_OPEN) else $error("wrong fault level");
  trip_off_a: assert property (!any_fault_n |-> phase_out == 4'h0) else $error("phases on after trip");
  step_a: assert property (ok[*3] ##0 ($rose(step_clock) || !edge_select && $fell(step_clock))
    |=> position == nxt($past(position), $past(excitation_select), $past(direction_select))) else $error("bad step");
  no_fall_a: assert property (edge_select && system_reset_n && $fell(step_clock) |=> $stable(position))
    else $error("stepped on falling edge");
  decode_a: assert property (ok[*3] |=> phase_out == DEC[4*$past(position) +: 4]) else $error("bad phases");
  cover property (ok ##1 $rose(step_clock));
  cover property (!any_fault_n);
  cover property (!enable ##1 enable);
endmodule : seq_chk

bind stepper_phase_sequencer seq_chk seq_chk_i (.*);

// file: tb/ctl_model.sv
/* Motion controller model driving step clock and modes.
   Assumes one caller; drives at the falling clock edge. */
`timescale 1ns/1ns
module ctl_model (
  input  wire logic clk,               // Clock
  output logic      step_clock,        // Step clock
  output logic      excitation_select, // Mode
  output logic      edge_select,       // Edges
  output logic      direction_select   // Direction
);
  initial {step_clock, excitation_select, edge_select, direction_select} = 4'h2;
  // Modes change only while the step clock rests
  task automatic set_mode(input logic [2:0] m);
    @(negedge clk);
    {excitation_select, edge_select, direction_select} = m;
    // Modes settle 7 us ahead of the next step edge
    repeat (700) @(negedge clk);
  endtask : set_mode
  // One level change, held 25 us (both edges, 20 kHz, 50 % duty) or 10 us (one edge, 50 kHz)
  task automatic toggle();
    @(negedge clk);
    step_clock = ~step_clock;
    repeat (edge_select ? 1000 : 2500) @(negedge clk);
  endtask : toggle
endmodule : ctl_model

// file: tb/tb_top.sv
/* Self-checking bench for the phase sequencer.
   Assumes the controller model drives step and mode pins. */
`timescale 1ns/1ns
module tb_top;
  localparam logic [31:0] DEC = 32'ha2645198; // Phases per position
  logic clk = 1'b0, rst_n = 1'b0, system_reset_n = 1'b1, enable = 1'b1;
  stepper_pkg::detect_s detect = 3'h0;
  stepper_pkg::phases_s phase_out;
  logic any_fault_n, any_fault_oe, step_clock, excitation_select, edge_select, direction_select;
  logic [1:0] fault_type_level;
  logic [2:0] position, pos_exp;
  int failures = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  ctl_model ctl_model_i (.*);
  stepper_phase_sequencer stepper_phase_sequencer_i (.*);
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      final_report();
    end
  end
  function automatic logic [2:0] nxt(logic [2:0] p, logic ex, logic dir);
    nxt = dir ? p - ((ex || !p[0]) ? 3'h1 : 3'h2) : p + ((ex || !p[0]) ? 3'h1 : 3'h2);
  endfunction : nxt
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // One step clock change, then position and phases
  task automatic step_chk();
    ctl_model_i.toggle();
    if (step_clock || !edge_select) pos_exp = nxt(pos_exp, excitation_select, direction_select);
    chk(position, pos_exp);
    chk(phase_out, DEC[4*pos_exp +: 4]);
  endtask : step_chk
  task automatic sys_pulse();
    system_reset_n = 1'b0;
    @(negedge clk) system_reset_n = 1'b1;
    pos_exp = 3'h1;
    // Wait 10 us after release before any step edge
    repeat (1000) @(negedge clk);
  endtask : sys_pulse
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    pos_exp = 3'h1;
    chk(position, pos_exp);
    repeat (3) @(negedge clk);
    chk(phase_out, 4'h9);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      ctl_model_i.set_mode(3'(m));
      repeat (3) step_chk();
    end
    $display("test modes done");
    enable = 1'b0;
    repeat (2) ctl_model_i.toggle();
    chk(phase_out, 4'h0);
    chk(position, pos_exp);
    enable = 1'b1;
    repeat (2) @(negedge clk);
    chk(phase_out, DEC[4*pos_exp +: 4]);
    $display("test enable done");
    sys_pulse();
    chk(position, pos_exp);
    step_chk();
    $display("test sysreset done");
    for (int k = 0; k < 3; k++) begin
      sys_pulse();
      detect = 3'h4 >> k;
      repeat (4) @(negedge clk);
      detect = 3'h0;
      chk({any_fault_n, any_fault_oe, fault_type_level}, {2'h1, 2'(k + 1)});
      chk(phase_out, 4'h0);
      ctl_model_i.toggle();
      chk(position, 3'h1);
    end
    sys_pulse();
    chk(any_fault_n, 1'b1);
    repeat (2) step_chk();
    $display("test faults done");
    final_report();
  end
endmodule : tb_top
